// [design/hip_pkg.sv]
// Shared constants for the host memory port: register map, field positions, codes
package hip_pkg;
  // Processor-side register addresses and the protected control region
  localparam logic [13:0] HIP_START_ADDR_REG = 14'h3FE0;
  localparam logic [13:0] HIP_OVERLAY_REG    = 14'h3FE7;
  localparam logic [13:0] HIP_CTRL_BASE      = 14'h3FE0;
  localparam logic [13:0] HIP_FETCH_START    = 14'h0000;
  // Field positions in the latch word and in the overlay register
  localparam int          HIP_LAT_OVL_BIT    = 15;
  localparam int          HIP_LAT_PM_BIT     = 14;
  localparam int          HIP_OVL_SHORT_BIT  = 14;
  // Reset values
  localparam logic [15:0] HIP_START_RST      = 16'h0000;
  localparam logic [15:0] HIP_OVL_RST        = 16'h0000;
  // Boot strap code: C=1, B=0, A=1
  localparam logic [2:0]  HIP_BOOT_MODE      = 3'h5;
  // Buffer entry: {pm, address, data}
  localparam int          HIP_BUF_W          = 39;
  // Controller register offsets and command codes
  localparam logic [3:0]  HIP_CMD_OFS        = 4'h0;
  localparam logic [3:0]  HIP_STAT_OFS       = 4'h4;
  localparam logic [1:0]  HIP_OP_LATCH       = 2'h0;
  localparam logic [1:0]  HIP_OP_WRITE       = 2'h1;
  localparam logic [1:0]  HIP_OP_READ        = 2'h2;
  localparam logic [1:0]  HIP_RESP_OKAY      = 2'h0;
  localparam logic [1:0]  HIP_RESP_SLVERR    = 2'h2;
endpackage

// [design/hip_if.sv]
// Pin-level carrier between the host controller and the device port
interface hip_if;
  logic        sel_n;
  logic        ale;
  logic        rd_n;
  logic        wr_n;
  logic [15:0] h_dout;
  logic        h_oe;
  logic [15:0] d_dout;
  logic        d_oe;
  logic        ack_out_n;
  logic        ack_oe;
  logic [15:0] bus;
  logic        ack_n;
  // Shared bus level; an undriven bus reads as zero
  assign bus   = h_oe ? h_dout : (d_oe ? d_dout : 16'h0000);
  // Board pulldown holds the acknowledge low when nobody drives it
  assign ack_n = ack_oe ? ack_out_n : 1'b0;
  modport dev  (input sel_n, ale, rd_n, wr_n, bus, output d_dout, d_oe, ack_out_n, ack_oe);
  modport host (output sel_n, ale, rd_n, wr_n, h_dout, h_oe, input bus, ack_n);
endinterface

// [design/hip_buf2.sv]
// Two-entry valid/ready buffer for write words on their way to memory
module hip_buf2
  import hip_pkg::*;
#(
  parameter int W = HIP_BUF_W
)(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic [W-1:0] slot_r   [2];
  logic [W-1:0] slot_nxt [2];
  logic         wp_r, wp_nxt, rp_r, rp_nxt;
  logic [1:0]   cnt_r, cnt_nxt;
  logic         push, pop;

  assign in_ready  = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data  = slot_r[rp_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  ////////////////////////////////////////////////////////////////////////
  // Pointer and count update; full stalls the writer, so nothing is lost
  always_comb
  begin
    slot_nxt = slot_r;
    wp_nxt   = wp_r;
    rp_nxt   = rp_r;
    if (push)
    begin
      slot_nxt[wp_r] = in_data;
      wp_nxt         = !wp_r;
    end
    if (pop)
      rp_nxt = !rp_r;
    cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      slot_r[0] <= '0;
      slot_r[1] <= '0;
      wp_r      <= 1'b0;
      rp_r      <= 1'b0;
      cnt_r     <= 2'h0;
    end
    else if (ce)
    begin
      slot_r <= slot_nxt;
      wp_r   <= wp_nxt;
      rp_r   <= rp_nxt;
      cnt_r  <= cnt_nxt;
    end
  end
endmodule

// [design/hip_device.sv]
// Device end of the host memory port: latch, access sequencer, registers, boot hold
module hip_device
  import hip_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  hip_if.dev               link,
  input  wire logic [2:0]  mode_pins,
  input  wire logic        cpu_we,
  input  wire logic [13:0] cpu_addr,
  input  wire logic [15:0] cpu_wdata,
  output logic      [15:0] cpu_rdata,
  output logic             mem_valid,
  output logic             mem_write,
  output logic             mem_pm,
  output logic      [13:0] mem_addr,
  output logic      [23:0] mem_wdata,
  input  wire logic        mem_ready,
  input  wire logic [23:0] mem_rdata,
  output logic      [7:0]  overlay_select,
  output logic             short_read_alt,
  output logic             run_enable,
  output logic      [13:0] fetch_start
);
  typedef enum {D_IDLE, D_SYNC, D_ACCESS, D_WAITRD, D_RDATA, D_EXTRA, D_HOLD} hip_dst_t;

  hip_dst_t     st_r, st_nxt;
  logic         ale_q_r, ale_q_nxt;
  logic [15:0]  lat_r, lat_nxt;
  logic [15:0]  start_r, start_nxt;
  logic [15:0]  ovl_r, ovl_nxt;
  logic         is_wr_r, is_wr_nxt;
  logic [15:0]  wdat_r, wdat_nxt;
  logic [15:0]  rdat_r, rdat_nxt;
  logic [15:0]  pm_hi_r, pm_hi_nxt;
  logic [7:0]   pm_lo_r, pm_lo_nxt;
  logic         pm_ph_r, pm_ph_nxt;
  logic         ack_n_r, ack_n_nxt;
  logic         doe_r, doe_nxt;
  logic [15:0]  cpu_rd_r, cpu_rd_nxt;
  logic         memv_r, memv_nxt, memw_r, memw_nxt, mempm_r, mempm_nxt;
  logic [13:0]  mema_r, mema_nxt;
  logic [23:0]  memd_r, memd_nxt;
  logic [2:0]   mode_r;
  logic         init_r, run_r, run_nxt;
  logic         buf_in_valid, buf_in_ready, buf_out_valid, buf_out_ready;
  logic [HIP_BUF_W-1:0] buf_in_data, buf_out_data;
  logic         fall, inc;
  logic         rd_issue;

  // Processor control registers sit at the top of data memory
  function automatic logic is_ctrl(input logic pm, input logic [13:0] a);
    is_ctrl = !pm && (a >= HIP_CTRL_BASE);
  endfunction

  // Write words queue here so a memory stall never drops a host write
  hip_buf2 #(.W(HIP_BUF_W)) u_wbuf (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .ce        (ce),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (buf_in_data),
    .out_valid (buf_out_valid),
    .out_ready (buf_out_ready),
    .out_data  (buf_out_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // Host sequencer, address latch and register file
  always_comb
  begin
    st_nxt       = st_r;
    ale_q_nxt    = link.ale && !link.sel_n;
    lat_nxt      = lat_r;
    start_nxt    = start_r;
    ovl_nxt      = ovl_r;
    is_wr_nxt    = is_wr_r;
    wdat_nxt     = wdat_r;
    rdat_nxt     = rdat_r;
    pm_hi_nxt    = pm_hi_r;
    pm_lo_nxt    = pm_lo_r;
    pm_ph_nxt    = pm_ph_r;
    buf_in_valid = 1'b0;
    buf_in_data  = {start_r[HIP_LAT_PM_BIT], start_r[13:0], pm_hi_r, wdat_r[7:0]};
    rd_issue     = 1'b0;
    inc          = 1'b0;
    // Value is sampled while the latch enable is high, applied on its fall
    if (link.ale && !link.sel_n)
      lat_nxt = link.bus;
    fall = ale_q_r && !(link.ale && !link.sel_n);
    if (fall && !lat_r[HIP_LAT_OVL_BIT])
    begin
      start_nxt = {1'b0, lat_r[14:0]};
      pm_ph_nxt = 1'b0;
    end
    else if (fall)
      ovl_nxt[7:0] = lat_r[7:0];
    else if (cpu_we && cpu_addr == HIP_START_ADDR_REG)
      start_nxt = {1'b0, cpu_wdata[14:0]};
    else if (cpu_we && cpu_addr == HIP_OVERLAY_REG)
      ovl_nxt = cpu_wdata;
    case (st_r)
      D_IDLE:
        if (!link.sel_n && (!link.rd_n || !link.wr_n))
        begin
          is_wr_nxt = !link.wr_n;
          wdat_nxt  = link.bus;
          st_nxt    = D_SYNC;
        end
      D_SYNC:
        st_nxt = D_ACCESS;
      D_ACCESS:
        if (is_wr_r && start_r[HIP_LAT_PM_BIT] && !pm_ph_r)
        begin
          pm_hi_nxt = wdat_r;
          pm_ph_nxt = 1'b1;
          st_nxt    = D_HOLD;
        end
        else if (is_wr_r && is_ctrl(start_r[HIP_LAT_PM_BIT], start_r[13:0]))
        begin
          inc    = 1'b1;
          st_nxt = D_HOLD;
        end
        else if (is_wr_r)
        begin
          if (!start_r[HIP_LAT_PM_BIT])
            buf_in_data = {1'b0, start_r[13:0], 8'h00, wdat_r};
          buf_in_valid = 1'b1;
          if (buf_in_ready)
          begin
            inc       = 1'b1;
            pm_ph_nxt = 1'b0;
            st_nxt    = D_HOLD;
          end
        end
        else if (start_r[HIP_LAT_PM_BIT] && pm_ph_r)
        begin
          rdat_nxt  = {8'h00, pm_lo_r};
          pm_ph_nxt = 1'b0;
          inc       = 1'b1;
          st_nxt    = D_HOLD;
        end
        else if (!buf_out_valid && !memv_r)
        begin
          rd_issue = 1'b1;
          st_nxt   = D_WAITRD;
        end
      D_WAITRD:
        if (memv_r && mem_ready)
          st_nxt = D_RDATA;
      D_RDATA:
      begin
        if (start_r[HIP_LAT_PM_BIT])
        begin
          rdat_nxt  = mem_rdata[23:8];
          pm_lo_nxt = mem_rdata[7:0];
          pm_ph_nxt = 1'b1;
        end
        else
        begin
          rdat_nxt = mem_rdata[15:0];
          inc      = 1'b1;
        end
        // Overlay bit picks the short-read variant: set gives the quick one
        st_nxt = ovl_r[HIP_OVL_SHORT_BIT] ? D_HOLD : D_EXTRA;
      end
      D_EXTRA:
        st_nxt = D_HOLD;
      D_HOLD:
        if (link.sel_n || (link.rd_n && link.wr_n))
          st_nxt = D_IDLE;
      default:
        st_nxt = D_IDLE;
    endcase
    if (inc)
      start_nxt[13:0] = start_r[13:0] + 14'h0001;
    // Acknowledge stays high from the strobe until the access finishes
    ack_n_nxt = (st_nxt == D_HOLD) ? 1'b0 : ((st_nxt == D_IDLE) ? !buf_in_ready : 1'b1);
    // Only memory data ever reaches the bus, never the port registers
    doe_nxt    = (st_nxt == D_HOLD) && !is_wr_nxt;
    cpu_rd_nxt = (cpu_addr == HIP_START_ADDR_REG) ? start_r :
                 ((cpu_addr == HIP_OVERLAY_REG) ? ovl_r : 16'h0000);
  end

  ////////////////////////////////////////////////////////////////////////
  // Memory steal stage: one request at a time, reads wait for writes to drain
  always_comb
  begin
    memv_nxt      = memv_r && !mem_ready;
    memw_nxt      = memw_r;
    mempm_nxt     = mempm_r;
    mema_nxt      = mema_r;
    memd_nxt      = memd_r;
    buf_out_ready = !memv_r;
    if (rd_issue)
    begin
      memv_nxt  = 1'b1;
      memw_nxt  = 1'b0;
      mempm_nxt = start_r[HIP_LAT_PM_BIT];
      mema_nxt  = start_r[13:0];
    end
    else if (buf_out_valid && !memv_r)
    begin
      memv_nxt  = 1'b1;
      memw_nxt  = 1'b1;
      mempm_nxt = buf_out_data[38];
      mema_nxt  = buf_out_data[37:24];
      memd_nxt  = buf_out_data[23:0];
    end
    // Boot hold lifts once program word zero actually lands in memory
    run_nxt = run_r;
    if (init_r)
      run_nxt = (mode_r != HIP_BOOT_MODE);
    else if (memv_r && mem_ready && memw_r && mempm_r && mema_r == HIP_FETCH_START)
      run_nxt = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // State registers; strap pins sampled while reset is held
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r     <= D_IDLE;
      ale_q_r  <= 1'b0;
      lat_r    <= 16'h0000;
      start_r  <= HIP_START_RST;
      ovl_r    <= HIP_OVL_RST;
      is_wr_r  <= 1'b0;
      wdat_r   <= 16'h0000;
      rdat_r   <= 16'h0000;
      pm_hi_r  <= 16'h0000;
      pm_lo_r  <= 8'h00;
      pm_ph_r  <= 1'b0;
      ack_n_r  <= 1'b1;
      doe_r    <= 1'b0;
      cpu_rd_r <= 16'h0000;
      memv_r   <= 1'b0;
      memw_r   <= 1'b0;
      mempm_r  <= 1'b0;
      mema_r   <= 14'h0000;
      memd_r   <= 24'h000000;
      mode_r   <= mode_pins;
      init_r   <= 1'b1;
      run_r    <= 1'b0;
    end
    else if (ce)
    begin
      st_r     <= st_nxt;
      ale_q_r  <= ale_q_nxt;
      lat_r    <= lat_nxt;
      start_r  <= start_nxt;
      ovl_r    <= ovl_nxt;
      is_wr_r  <= is_wr_nxt;
      wdat_r   <= wdat_nxt;
      rdat_r   <= rdat_nxt;
      pm_hi_r  <= pm_hi_nxt;
      pm_lo_r  <= pm_lo_nxt;
      pm_ph_r  <= pm_ph_nxt;
      ack_n_r  <= ack_n_nxt;
      doe_r    <= doe_nxt;
      cpu_rd_r <= cpu_rd_nxt;
      memv_r   <= memv_nxt;
      memw_r   <= memw_nxt;
      mempm_r  <= mempm_nxt;
      mema_r   <= mema_nxt;
      memd_r   <= memd_nxt;
      init_r   <= 1'b0;
      run_r    <= run_nxt;
    end
  end

  // Acknowledge is driven only after reset; the pulldown covers reset time
  assign link.ack_out_n = ack_n_r;
  assign link.ack_oe    = !init_r;
  assign link.d_dout    = rdat_r;
  assign link.d_oe      = doe_r;
  assign cpu_rdata      = cpu_rd_r;
  assign mem_valid      = memv_r;
  assign mem_write      = memw_r;
  assign mem_pm         = mempm_r;
  assign mem_addr       = mema_r;
  assign mem_wdata      = memd_r;
  assign overlay_select = ovl_r[7:0];
  assign short_read_alt = ovl_r[HIP_OVL_SHORT_BIT];
  assign run_enable     = run_r;
  assign fetch_start    = HIP_FETCH_START;
endmodule

// [design/hip_host.sv]
// Host end: AXI4-Lite command registers driving the port pins
module hip_host
  import hip_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic [3:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic      [1:0]  s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [3:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic      [31:0] s_rdata,
  output logic      [1:0]  s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  hip_if.host              link
);
  typedef enum {H_IDLE, H_WAITACK, H_LATCH, H_LATEND, H_STROBE, H_DONE} hip_hst_t;

  hip_hst_t    st_r, st_nxt;
  logic        awh_r, awh_nxt, wh_r, wh_nxt;
  logic [3:0]  awa_r, awa_nxt;
  logic [31:0] wd_r, wd_nxt;
  logic        awr_r, awr_nxt, wr_r, wr_nxt, bv_r, bv_nxt, arr_r, arr_nxt, rv_r, rv_nxt;
  logic [1:0]  br_r, br_nxt, rr_r, rr_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic [1:0]  op_r, op_nxt;
  logic [15:0] val_r, val_nxt, got_r, got_nxt;
  logic        busy_r, busy_nxt;
  logic        sel_n_r, sel_n_nxt, ale_r, ale_nxt, rdn_r, rdn_nxt, wrn_r, wrn_nxt, hoe_r, hoe_nxt;
  logic [15:0] hout_r, hout_nxt;

  ////////////////////////////////////////////////////////////////////////
  // Register slave and pin sequencer
  always_comb
  begin
    st_nxt = st_r;
    awh_nxt = awh_r;  awa_nxt = awa_r;  wh_nxt = wh_r;  wd_nxt = wd_r;
    bv_nxt = bv_r && !s_bready;
    br_nxt = br_r;
    rv_nxt = rv_r && !s_rready;
    rr_nxt = rr_r;  rd_nxt = rd_r;
    op_nxt = op_r;  val_nxt = val_r;  got_nxt = got_r;  busy_nxt = busy_r;
    sel_n_nxt = sel_n_r;  ale_nxt = ale_r;  rdn_nxt = rdn_r;  wrn_nxt = wrn_r;
    hoe_nxt = hoe_r;  hout_nxt = hout_r;
    // Address and data may arrive in either order
    if (s_awvalid && awr_r)
    begin
      awh_nxt = 1'b1;
      awa_nxt = s_awaddr;
    end
    if (s_wvalid && wr_r)
    begin
      wh_nxt = 1'b1;
      wd_nxt = s_wdata;
    end
    if (awh_r && wh_r && !bv_r)
    begin
      awh_nxt = 1'b0;
      wh_nxt  = 1'b0;
      bv_nxt  = 1'b1;
      br_nxt  = (awa_r == HIP_CMD_OFS || awa_r == HIP_STAT_OFS) ? HIP_RESP_OKAY : HIP_RESP_SLVERR;
      // A command while busy is ignored; software polls busy first
      if (awa_r == HIP_CMD_OFS && !busy_r && wd_r[1:0] != 2'h3)
      begin
        op_nxt   = wd_r[1:0];
        val_nxt  = wd_r[31:16];
        busy_nxt = 1'b1;
        st_nxt   = H_WAITACK;
      end
    end
    if (s_arvalid && arr_r)
    begin
      rv_nxt = 1'b1;
      rr_nxt = HIP_RESP_OKAY;
      if (s_araddr == HIP_STAT_OFS)
        rd_nxt = {got_r, 15'h0000, busy_r};
      else if (s_araddr == HIP_CMD_OFS)
        rd_nxt = {val_r, 14'h0000, op_r};
      else
      begin
        rd_nxt = 32'h00000000;
        rr_nxt = HIP_RESP_SLVERR;
      end
    end
    case (st_r)
      H_IDLE:
        st_nxt = st_nxt;
      H_WAITACK:
        if (!link.ack_n)
        begin
          sel_n_nxt = 1'b0;
          hout_nxt  = val_r;
          if (op_r == HIP_OP_LATCH)
          begin
            ale_nxt = 1'b1;
            hoe_nxt = 1'b1;
            st_nxt  = H_LATCH;
          end
          else
          begin
            // Only one strobe ever goes low at a time
            rdn_nxt = (op_r != HIP_OP_READ);
            wrn_nxt = (op_r != HIP_OP_WRITE);
            hoe_nxt = (op_r == HIP_OP_WRITE);
            st_nxt  = H_STROBE;
          end
        end
      H_LATCH:
      begin
        ale_nxt = 1'b0;
        st_nxt  = H_LATEND;
      end
      H_LATEND:
      begin
        sel_n_nxt = 1'b1;
        hoe_nxt   = 1'b0;
        busy_nxt  = 1'b0;
        st_nxt    = H_IDLE;
      end
      H_STROBE:
        if (link.ack_n)
          st_nxt = H_DONE;
      H_DONE:
        if (!link.ack_n)
        begin
          if (op_r == HIP_OP_READ)
            got_nxt = link.bus;
          sel_n_nxt = 1'b1;
          rdn_nxt   = 1'b1;
          wrn_nxt   = 1'b1;
          hoe_nxt   = 1'b0;
          busy_nxt  = 1'b0;
          st_nxt    = H_IDLE;
        end
      default:
        st_nxt = H_IDLE;
    endcase
    awr_nxt = !awh_nxt && !bv_nxt;
    wr_nxt  = !wh_nxt && !bv_nxt;
    arr_nxt = !rv_nxt;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r <= H_IDLE;
      awh_r <= 1'b0;  awa_r <= 4'h0;  wh_r <= 1'b0;  wd_r <= 32'h00000000;
      awr_r <= 1'b0;  wr_r <= 1'b0;  bv_r <= 1'b0;  br_r <= HIP_RESP_OKAY;
      arr_r <= 1'b0;  rv_r <= 1'b0;  rr_r <= HIP_RESP_OKAY;  rd_r <= 32'h00000000;
      op_r <= HIP_OP_LATCH;  val_r <= 16'h0000;  got_r <= 16'h0000;  busy_r <= 1'b0;
      sel_n_r <= 1'b1;  ale_r <= 1'b0;  rdn_r <= 1'b1;  wrn_r <= 1'b1;
      hoe_r <= 1'b0;  hout_r <= 16'h0000;
    end
    else if (ce)
    begin
      st_r <= st_nxt;
      awh_r <= awh_nxt;  awa_r <= awa_nxt;  wh_r <= wh_nxt;  wd_r <= wd_nxt;
      awr_r <= awr_nxt;  wr_r <= wr_nxt;  bv_r <= bv_nxt;  br_r <= br_nxt;
      arr_r <= arr_nxt;  rv_r <= rv_nxt;  rr_r <= rr_nxt;  rd_r <= rd_nxt;
      op_r <= op_nxt;  val_r <= val_nxt;  got_r <= got_nxt;  busy_r <= busy_nxt;
      sel_n_r <= sel_n_nxt;  ale_r <= ale_nxt;  rdn_r <= rdn_nxt;  wrn_r <= wrn_nxt;
      hoe_r <= hoe_nxt;  hout_r <= hout_nxt;
    end
  end

  assign s_awready   = awr_r;
  assign s_wready    = wr_r;
  assign s_bvalid    = bv_r;
  assign s_bresp     = br_r;
  assign s_arready   = arr_r;
  assign s_rvalid    = rv_r;
  assign s_rresp     = rr_r;
  assign s_rdata     = rd_r;
  assign link.sel_n  = sel_n_r;
  assign link.ale    = ale_r;
  assign link.rd_n   = rdn_r;
  assign link.wr_n   = wrn_r;
  assign link.h_oe   = hoe_r;
  assign link.h_dout = hout_r;
endmodule

// [verif/hip_checker.sv]
// Pin-level checker for the link between host and device ends
module hip_checker (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        sel_n,
  input  wire logic        ale,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic        h_oe,
  input  wire logic        d_oe,
  input  wire logic        ack_n,
  input  wire logic [15:0] bus
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////
  // Strobe and latch framing driven by the host end
  property p_excl; !(!rd_n && !wr_n); endproperty
  a_excl: assert property (p_excl) else $error("both strobes low");
  property p_ale; ale |-> !sel_n && rd_n && wr_n; endproperty
  a_ale: assert property (p_ale) else $error("latch outside select");
  property p_ovl; (ale && bus[15]) |-> bus[14:8] == 7'h00; endproperty
  a_ovl: assert property (p_ovl) else $error("overlay high bits set");
  property p_fall; $fell(ale) |-> !sel_n; endproperty
  a_fall: assert property (p_fall) else $error("select gone at latch fall");
  // Bus ownership: only one end may drive, never the host during a read
  property p_fight; d_oe |-> (!h_oe && rd_n == 1'b0) || ($past(rd_n) == 1'b0); endproperty
  a_fight: assert property (p_fight) else $error("bus driven by both");
  property p_hold; (!wr_n && ack_n) |=> !wr_n && !sel_n; endproperty
  a_hold: assert property (p_hold) else $error("write dropped early");
  // Acknowledge timing: sync plus access, reads take at least four cycles
  property p_wr; $fell(wr_n) |=> ack_n ##[1:30] !ack_n; endproperty
  a_wr: assert property (p_wr) else $error("write ack timing");
  property p_rd; $fell(rd_n) |=> ack_n [*3] ##[1:40] !ack_n; endproperty
  a_rd: assert property (p_rd) else $error("read ack timing");
  c_wr: cover property ($fell(wr_n));
  c_rd: cover property ($fell(rd_n));
  c_ovl: cover property (ale && bus[15]);
endmodule

// [verif/host_internal_memory_port_tb_top.sv]
// Bench top: both ends joined, driven over AXI4-Lite and the processor side
module host_internal_memory_port_tb_top import hip_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic        aclk = 1'b0, aresetn = 1'b0, stall = 1'b0, mem_ready = 1'b0, cpu_we = 1'b0;
  logic        s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid, mem_valid, mem_write, mem_pm;
  logic        short_read_alt, run_enable;
  logic [3:0]  s_awaddr = 4'h0, s_araddr = 4'h0;
  logic [31:0] s_wdata = 32'h0, s_rdata, s;
  logic [1:0]  s_bresp, s_rresp, r;
  logic [13:0] cpu_addr = 14'h0, mem_addr, fetch_start;
  logic [15:0] cpu_wdata = 16'h0, cpu_rdata;
  logic [23:0] mem_wdata, mem_rdata = 24'h0, pmem [0:63], dmem [0:63];
  logic [7:0]  overlay_select;
  int          fail_count = 0, n_checks = 0, wcnt = 0, n;
  ////////////////////////////////////////////////////////////
  hip_if hip_if_i ();
  hip_host hip_host_i (.aclk, .aresetn, .ce(1'b1), .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
    .s_wstrb(4'hF), .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
    .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .link(hip_if_i));
  hip_device hip_device_i (.aclk, .aresetn, .ce(1'b1), .link(hip_if_i), .mode_pins(HIP_BOOT_MODE),
    .cpu_we, .cpu_addr, .cpu_wdata, .cpu_rdata, .mem_valid, .mem_write, .mem_pm, .mem_addr,
    .mem_wdata, .mem_ready, .mem_rdata, .overlay_select, .short_read_alt, .run_enable, .fetch_start);
  hip_checker hip_checker_i (.aclk, .aresetn, .sel_n(hip_if_i.sel_n), .ale(hip_if_i.ale),
    .rd_n(hip_if_i.rd_n), .wr_n(hip_if_i.wr_n), .h_oe(hip_if_i.h_oe), .d_oe(hip_if_i.d_oe),
    .ack_n(hip_if_i.ack_n), .bus(hip_if_i.bus));
  initial forever #5 aclk = ~aclk;
  // Memory answers every other cycle, not at all while stalled, so the write buffer backs up
  always @(posedge aclk)
  begin
    mem_ready <= !stall && !mem_ready;
    if (mem_valid && mem_ready && mem_write && mem_pm) pmem[mem_addr[5:0]] <= mem_wdata;
    if (mem_valid && mem_ready && mem_write && !mem_pm) dmem[mem_addr[5:0]] <= mem_wdata;
    if (mem_valid && mem_ready && mem_write) wcnt <= wcnt + 1;
    if (mem_valid && mem_ready) mem_rdata <= mem_pm ? pmem[mem_addr[5:0]] : dmem[mem_addr[5:0]];
  end
  ////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      fail_count++;
    end
  endtask
  // Each task opens one edge later so no strobe is assigned twice in a time step
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
      if (s_bvalid) break;
    end
    r = s_bresp;
    s_bready <= 1'b0;
  endtask
  task automatic axr(input logic [3:0] a);
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
      if (s_rvalid) break;
    end
    s = s_rdata;
    r = s_rresp;
    s_rready <= 1'b0;
  endtask
  // Command waits for idle, then for completion, leaving the final status in s
  task automatic cmd(input logic [1:0] op, input logic [15:0] v);
    s = 32'h1;
    while (s[0] !== 1'b0) axr(HIP_STAT_OFS);
    axw(HIP_CMD_OFS, {v, 14'h0000, op});
    s = 32'h1;
    while (s[0] !== 1'b0) axr(HIP_STAT_OFS);
  endtask
  task automatic cpu(input logic [13:0] a, input logic [15:0] d);
    cpu_addr <= a;
    cpu_wdata <= d;
    cpu_we <= 1'b1;
    @(posedge aclk);
    cpu_we <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask
  ////////////////////////////////////////////////////////////
  // Watchdog: a hang counts as a mismatch
  initial
  begin
    repeat (40000) @(posedge aclk);
    fail_count++;
    stop_test;
  end
  initial
  begin
    repeat (16) @(posedge aclk);
    // Device leaves the acknowledge undriven in reset, so the board pulldown must show
    chk(32'(hip_if_i.ack_n), 32'h0);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(32'(run_enable), 32'h0);
    chk(32'(fetch_start), 32'(HIP_FETCH_START));
    axw(4'h8, 32'h0);
    chk(32'(r), 32'(HIP_RESP_SLVERR));
    axr(4'h8);
    chk({s[29:0], r}, 32'(HIP_RESP_SLVERR));
    cmd(HIP_OP_LATCH, 16'h0010);
    cmd(HIP_OP_WRITE, 16'h1234);
    cmd(HIP_OP_WRITE, 16'h5678);
    cmd(HIP_OP_LATCH, 16'h0010);
    cmd(HIP_OP_READ, 16'h0000);
    chk(s >> 16, 32'h1234);
    cmd(HIP_OP_READ, 16'h0000);
    chk(s >> 16, 32'h5678);
    chk(32'(dmem[17][15:0]), 32'h5678);
    // Stall memory: two words must wait, one in the memory request and one in the buffer; after release only the first and third words are checked
    n = wcnt;
    stall <= 1'b1;
    cmd(HIP_OP_LATCH, 16'h0020);
    cmd(HIP_OP_WRITE, 16'hA001);
    cmd(HIP_OP_WRITE, 16'hA002);
    chk(32'(wcnt), 32'(n));
    stall <= 1'b0;
    cmd(HIP_OP_WRITE, 16'hA003);
    repeat (20) @(posedge aclk);
    chk({dmem[32][15:0], dmem[34][15:0]}, 32'hA001A003);
    n = wcnt;
    cmd(HIP_OP_LATCH, 16'h3FE0);
    cmd(HIP_OP_WRITE, 16'hDEAD);
    repeat (20) @(posedge aclk);
    chk(32'(wcnt), 32'(n));
    chk(32'(run_enable), 32'h0);
    cmd(HIP_OP_LATCH, 16'h4000);
    cmd(HIP_OP_WRITE, 16'hABCD);
    cmd(HIP_OP_WRITE, 16'h00EF);
    repeat (20) @(posedge aclk);
    chk(32'(pmem[0]), 32'hABCDEF);
    chk(32'(run_enable), 32'h1);
    cpu(HIP_OVERLAY_REG, 16'h4000);
    chk(32'(short_read_alt), 32'h1);
    cmd(HIP_OP_LATCH, 16'h805A);
    chk(32'(overlay_select), 32'h5A);
    cpu(HIP_START_ADDR_REG, 16'h0123);
    chk(32'(cpu_rdata), 32'h0123);
    cmd(HIP_OP_LATCH, 16'h0010);
    cmd(HIP_OP_READ, 16'h0000);
    chk(s >> 16, 32'h1234);
    stop_test;
  end
endmodule
